/* core/dtp_pkg.sv */
// Purpose: Shared constants for the dual timer and PWM block
// Assumes: APB word access, register index times four is the byte address
// Notes: Register indices are kept as printed or chosen

package dtp_pkg;

  // ***************************************************************
  // Bus and widths
  // ***************************************************************
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int IW = 14;
  localparam int CW = 8;
  localparam int PW = 10;
  localparam int PRW = 14;

  // ***************************************************************
  // Register indices (byte address is index times four)
  // ***************************************************************
  localparam logic [IW-1:0] IDX_TA_CTRL = 14'h1000;
  localparam logic [IW-1:0] IDX_TB_CTRL = 14'h1002;
  localparam logic [IW-1:0] IDX_PCR1 = 14'h1003;
  localparam logic [IW-1:0] IDX_PCR2 = 14'h1004;
  localparam logic [IW-1:0] IDX_PCR3 = 14'h1005;
  localparam logic [IW-1:0] IDX_TA_CMP = 14'h1006;
  localparam logic [IW-1:0] IDX_TB_CMP = 14'h1007;
  localparam logic [IW-1:0] IDX_TA_CNT = 14'h1008;
  localparam logic [IW-1:0] IDX_TB_CNT = 14'h1009;
  localparam logic [IW-1:0] IDX_TA_CAP = 14'h100A;
  localparam logic [IW-1:0] IDX_TB_CAP = 14'h100B;
  localparam logic [IW-1:0] IDX_PERIOD = 14'h100C;
  localparam logic [IW-1:0] IDX_DUTY_A = 14'h100D;
  localparam logic [IW-1:0] IDX_DUTY_B = 14'h100E;
  localparam logic [IW-1:0] IDX_DUTY_C = 14'h100F;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int B_TA_RUN = 7;
  localparam int B_TA_CAPSEL = 6;
  localparam int B_COMBINE = 7;
  localparam int B_TB_CAPSEL = 6;
  localparam int B_TB_RUN = 5;
  localparam int B_TB_CLR = 4;
  localparam int B_PWM_EN = 7;
  localparam int B_BLANK_SYNC_ENABLE = 6;
  localparam int B_UPDOWN = 5;
  localparam int B_HALT = 4;
  localparam int B_IMM = 3;
  localparam int B_WALL = 2;
  localparam int B_FORCE = 7;
  localparam int B_HIGH_Z_CLEAR = 7;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] PCR2_MASK = 8'hBF;
  localparam logic [7:0] PCR3_MASK = 8'h3F;
  localparam logic [7:0] TB_MASK = 8'hEF;
  localparam logic [2:0] TA_EXT_SEL = 3'h7;
  localparam logic [3:0] TB_CHAIN_SEL = 4'hF;

  // ***************************************************************
  // Operating modes
  // ***************************************************************
  typedef enum logic [2:0] {
    MODE_T8 = 3'b000,
    MODE_CAP8 = 3'b001,
    MODE_T16 = 3'b010,
    MODE_CAP16 = 3'b011,
    MODE_PWM = 3'b100
  } dtp_mode_t;

  // Timer A divider exponent per select code
  function automatic logic [3:0] dtp_ta_log(input logic [2:0] sel);
    case (sel)
      3'h0: dtp_ta_log = 4'h1;
      3'h1: dtp_ta_log = 4'h2;
      3'h2: dtp_ta_log = 4'h3;
      3'h3: dtp_ta_log = 4'h5;
      3'h4: dtp_ta_log = 4'h7;
      3'h5: dtp_ta_log = 4'h9;
      default: dtp_ta_log = 4'hB;
    endcase
  endfunction

  // One-cycle tick of system clock divided by two to the power n
  function automatic logic dtp_tick(input logic [PRW-1:0] p, input logic [3:0] n);
    logic [PRW-1:0] m;
    m = (14'h0001 << n) - 14'h0001;
    dtp_tick = ((p & m) == m);
  endfunction

endpackage

/* core/dtp_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to core_clk
// Notes: Level follows once stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module dtp_sync #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } dtp_sync_t;

  dtp_sync_t s_r;
  dtp_sync_t s_nxt;
  logic [W-1:0] agree;

  always_comb
  begin
    s_nxt = s_r;
    agree = ~(s_r.s2 ^ s_r.s3);
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.lvl = (agree & s_r.s3) | (~agree & s_r.lvl);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign level = s_r.lvl;

endmodule

`default_nettype wire

/* core/dtp_top.sv */
// Purpose: Two 8-bit timers, 16-bit combine, capture and 10-bit PWM
// Assumes: APB slave with zero wait states, one register per word
// Notes: Pin inputs pass dtp_sync before use
//
// The APB interface to the registers is this design's own decision.

`timescale 1ns/1ps
`default_nettype none

module dtp_top
  import dtp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [dtp_pkg::AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtp_pkg::DW-1:0] pwdata,
  output logic [dtp_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_clock,
  input wire logic capture_event_in0,
  input wire logic capture_event_in1,
  input wire logic blanking_input,
  output logic timer_a_out_pin,
  output logic timer_b_out_pin,
  output logic [5:0] pwm_pin_out,
  output logic [5:0] pwm_pin_oe
);
  import dtp_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [PRW-1:0] presc;
    logic [7:0] ta_ctrl;
    logic [7:0] tb_ctrl;
    logic [7:0] pcr1;
    logic [7:0] pcr2;
    logic [7:0] pcr3;
    logic [CW-1:0] ta_cmp;
    logic [CW-1:0] tb_cmp;
    logic [CW-1:0] ta_cnt;
    logic [CW-1:0] tb_cnt;
    logic [CW-1:0] ta_cap;
    logic [CW-1:0] tb_cap;
    logic [PW-1:0] per_buf;
    logic [PW-1:0] per;
    logic [2:0][PW-1:0] dty_buf;
    logic [2:0][PW-1:0] dty;
    logic [PW-1:0] pcnt;
    logic down;
    logic [2:0] nps;
    logic blank;
    logic [3:0] prev;
    logic ta_out;
    logic tb_out;
    logic [5:0] pin_o;
    logic [5:0] pin_e;
    logic [DW-1:0] rdata;
  } dtp_state_t;

  dtp_state_t s_r;
  dtp_state_t s_nxt;
  dtp_mode_t mode;
  logic [3:0] lvl;
  logic [3:0] rise;
  logic ta_tick;
  logic tb_tick;
  logic pstep;
  logic pm;
  logic wr;
  logic hit;
  logic tb_clr;
  logic hz_clr;
  logic wall;
  logic imm;
  logic [IW-1:0] idx;
  logic [2:0] nmask;
  logic [PW-1:0] lim;
  logic [2:0] wave;
  logic [5:0] raw;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  dtp_sync #(
    .W(4)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({blanking_input, capture_event_in1, capture_event_in0, external_count_clock}),
    .level(lvl)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    s_nxt = s_r;
    idx = paddr[AW-1:2];
    wr = psel & penable & pwrite;
    rise = lvl & ~s_r.prev;
    s_nxt.prev = lvl;
    wall = s_r.pcr1[B_WALL];
    imm = s_r.pcr1[B_IMM];
    // Mode decode
    if (s_r.pcr1[B_PWM_EN] && !s_r.tb_ctrl[B_COMBINE])
      mode = MODE_PWM;
    else if (s_r.tb_ctrl[B_COMBINE])
      mode = (s_r.ta_ctrl[B_TA_CAPSEL] && s_r.tb_ctrl[B_TB_CAPSEL]) ? MODE_CAP16 : MODE_T16;
    else
      mode = (s_r.ta_ctrl[B_TA_CAPSEL] && s_r.tb_ctrl[B_TB_CAPSEL]) ? MODE_CAP8 : MODE_T8;
    // Clock sources
    s_nxt.presc = s_r.presc + 14'h0001;
    if (s_r.ta_ctrl[2:0] == TA_EXT_SEL)
      ta_tick = rise[0];
    else
      ta_tick = dtp_tick(s_r.presc, dtp_ta_log(s_r.ta_ctrl[2:0]));
    if (s_r.tb_ctrl[3:0] == TB_CHAIN_SEL)
      tb_tick = ta_tick;
    else
      tb_tick = dtp_tick(s_r.presc, s_r.tb_ctrl[3:0]);
    // Timer counters
    case (mode)
      MODE_T8, MODE_PWM:
      begin
        if (s_r.ta_ctrl[B_TA_RUN] && ta_tick)
        begin
          if (s_r.ta_cnt == s_r.ta_cmp)
          begin
            s_nxt.ta_cnt = '0;
            s_nxt.ta_out = ~s_r.ta_out;
          end
          else
            s_nxt.ta_cnt = s_r.ta_cnt + 8'h01;
        end
        if (mode == MODE_T8 && s_r.tb_ctrl[B_TB_RUN] && tb_tick)
        begin
          if (s_r.tb_cnt == s_r.tb_cmp)
          begin
            s_nxt.tb_cnt = '0;
            s_nxt.tb_out = ~s_r.tb_out;
          end
          else
            s_nxt.tb_cnt = s_r.tb_cnt + 8'h01;
        end
      end
      MODE_CAP8:
      begin
        if (s_r.ta_ctrl[B_TA_RUN] && ta_tick)
          s_nxt.ta_cnt = s_r.ta_cnt + 8'h01;
        if (s_r.tb_ctrl[B_TB_RUN] && tb_tick)
          s_nxt.tb_cnt = s_r.tb_cnt + 8'h01;
        if (rise[1])
          s_nxt.ta_cap = s_r.ta_cnt;
        if (rise[2])
          s_nxt.tb_cap = s_r.tb_cnt;
      end
      MODE_T16, MODE_CAP16:
      begin
        if (s_r.ta_ctrl[B_TA_RUN] && ta_tick)
        begin
          if (mode == MODE_T16 && {s_r.tb_cnt, s_r.ta_cnt} == {s_r.tb_cmp, s_r.ta_cmp})
          begin
            {s_nxt.tb_cnt, s_nxt.ta_cnt} = '0;
            s_nxt.ta_out = ~s_r.ta_out;
          end
          else
            {s_nxt.tb_cnt, s_nxt.ta_cnt} = {s_r.tb_cnt, s_r.ta_cnt} + 16'h0001;
        end
        if (mode == MODE_CAP16 && rise[1])
          {s_nxt.tb_cap, s_nxt.ta_cap} = {s_r.tb_cnt, s_r.ta_cnt};
      end
      default:
      begin
        s_nxt.ta_cnt = s_r.ta_cnt;
      end
    endcase
    // PWM counter and non-overlap prescaler
    nmask = (3'h1 << s_r.pcr1[1:0]) - 3'h1;
    pstep = 1'b0;
    pm = 1'b0;
    if (mode == MODE_PWM && !s_r.pcr1[B_HALT] && tb_tick)
    begin
      s_nxt.nps = s_r.nps + 3'h1;
      pstep = ((s_r.nps & nmask) == nmask);
    end
    if (pstep)
    begin
      if (!s_r.pcr1[B_UPDOWN])
      begin
        if (s_r.pcnt >= s_r.per)
        begin
          s_nxt.pcnt = '0;
          pm = 1'b1;
        end
        else
          s_nxt.pcnt = s_r.pcnt + 10'h001;
      end
      else if (!s_r.down)
      begin
        if (s_r.pcnt >= s_r.per)
        begin
          s_nxt.down = 1'b1;
          pm = 1'b1;
        end
        else
          s_nxt.pcnt = s_r.pcnt + 10'h001;
      end
      else if (s_r.pcnt == '0)
        s_nxt.down = 1'b0;
      else
        s_nxt.pcnt = s_r.pcnt - 10'h001;
    end
    if (pm && !imm)
    begin
      s_nxt.per = s_r.per_buf;
      s_nxt.dty = s_r.dty_buf;
    end
    // Register writes
    tb_clr = 1'b0;
    hit = 1'b1;
    case (idx)
      IDX_TA_CTRL, IDX_TB_CTRL, IDX_PCR1, IDX_PCR2, IDX_PCR3, IDX_TA_CMP, IDX_TB_CMP,
      IDX_TA_CNT, IDX_TB_CNT, IDX_TA_CAP, IDX_TB_CAP, IDX_PERIOD, IDX_DUTY_A,
      IDX_DUTY_B, IDX_DUTY_C:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    // Blanking latch, set wins over clear
    hz_clr = wr && hit && idx == IDX_PCR3 && pwdata[B_HIGH_Z_CLEAR];
    s_nxt.blank = (hz_clr ? 1'b0 : s_r.blank) | (s_r.pcr1[B_BLANK_SYNC_ENABLE] & rise[3]);
    if (wr)
    begin
      case (idx)
        IDX_TA_CTRL: s_nxt.ta_ctrl = pwdata[7:0];
        IDX_TB_CTRL:
        begin
          s_nxt.tb_ctrl = pwdata[7:0] & TB_MASK;
          tb_clr = pwdata[B_TB_CLR];
        end
        IDX_PCR1: s_nxt.pcr1 = pwdata[7:0];
        IDX_PCR2: s_nxt.pcr2 = pwdata[7:0] & PCR2_MASK;
        IDX_PCR3: s_nxt.pcr3 = pwdata[7:0] & PCR3_MASK;
        IDX_TA_CMP: s_nxt.ta_cmp = pwdata[7:0];
        IDX_TB_CMP: s_nxt.tb_cmp = pwdata[7:0];
        IDX_PERIOD:
        begin
          s_nxt.per_buf = pwdata[PW-1:0];
          if (imm)
            s_nxt.per = pwdata[PW-1:0];
        end
        IDX_DUTY_A:
        begin
          s_nxt.dty_buf[0] = pwdata[PW-1:0];
          if (wall)
          begin
            s_nxt.dty_buf[1] = pwdata[PW-1:0];
            s_nxt.dty_buf[2] = pwdata[PW-1:0];
          end
          if (imm)
            s_nxt.dty[0] = pwdata[PW-1:0];
          if (imm && wall)
          begin
            s_nxt.dty[1] = pwdata[PW-1:0];
            s_nxt.dty[2] = pwdata[PW-1:0];
          end
        end
        IDX_DUTY_B:
        begin
          s_nxt.dty_buf[1] = pwdata[PW-1:0];
          if (imm)
            s_nxt.dty[1] = pwdata[PW-1:0];
        end
        IDX_DUTY_C:
        begin
          s_nxt.dty_buf[2] = pwdata[PW-1:0];
          if (imm)
            s_nxt.dty[2] = pwdata[PW-1:0];
        end
        default: hit = hit;
      endcase
    end
    if (tb_clr)
    begin
      s_nxt.tb_cnt = '0;
      s_nxt.pcnt = '0;
      s_nxt.down = 1'b0;
      s_nxt.nps = '0;
    end
    // PWM pins
    for (int i = 0; i < 3; i++)
    begin
      lim = s_r.pcr2[B_FORCE] ? s_r.dty[0] : s_r.dty[i];
      wave[i] = (s_r.pcnt < lim);
    end
    raw = {wave[0], ~wave[0], wave[1], ~wave[1], wave[2], ~wave[2]};
    s_nxt.pin_o = raw ^ s_r.pcr3[5:0];
    if (mode == MODE_PWM && !s_r.pcr1[B_HALT] && !(s_r.pcr1[B_BLANK_SYNC_ENABLE] && s_r.blank))
      s_nxt.pin_e = s_r.pcr2[5:0];
    else
      s_nxt.pin_e = 6'h00;
    // Read data captured in the setup phase
    if (psel && !penable)
    begin
      case (idx)
        IDX_TA_CTRL: s_nxt.rdata = {24'h000000, s_r.ta_ctrl};
        IDX_TB_CTRL: s_nxt.rdata = {24'h000000, s_r.tb_ctrl};
        IDX_PCR1: s_nxt.rdata = {24'h000000, s_r.pcr1};
        IDX_PCR2: s_nxt.rdata = {24'h000000, s_r.pcr2};
        IDX_PCR3: s_nxt.rdata = {24'h000000, s_r.pcr3};
        IDX_TA_CMP: s_nxt.rdata = {24'h000000, s_r.ta_cmp};
        IDX_TB_CMP: s_nxt.rdata = {24'h000000, s_r.tb_cmp};
        IDX_TA_CNT: s_nxt.rdata = {24'h000000, s_r.ta_cnt};
        IDX_TB_CNT: s_nxt.rdata = {22'h000000, s_r.pcnt | {2'h0, s_r.tb_cnt}};
        IDX_TA_CAP: s_nxt.rdata = {24'h000000, s_r.ta_cap};
        IDX_TB_CAP: s_nxt.rdata = {24'h000000, s_r.tb_cap};
        IDX_PERIOD: s_nxt.rdata = {22'h000000, s_r.per_buf};
        IDX_DUTY_A: s_nxt.rdata = {22'h000000, s_r.dty_buf[0]};
        IDX_DUTY_B: s_nxt.rdata = {22'h000000, s_r.dty_buf[1]};
        IDX_DUTY_C: s_nxt.rdata = {22'h000000, s_r.dty_buf[2]};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign timer_a_out_pin = s_r.ta_out;
  assign timer_b_out_pin = s_r.tb_out;
  assign pwm_pin_out = s_r.pin_o;
  assign pwm_pin_oe = s_r.pin_e;

  // ***************************************************************
  // Checks
  // ***************************************************************
  AST_T8_TOGGLE: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode == MODE_T8 && s_r.ta_ctrl[B_TA_RUN] && ta_tick && s_r.ta_cnt == s_r.ta_cmp)
    |=> (s_r.ta_out != $past(s_r.ta_out)) && (s_r.ta_cnt == 8'h00))
    else $error("timer A did not toggle on match");
  AST_CAP8: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode == MODE_CAP8 && rise[1]) |=> s_r.ta_cap == $past(s_r.ta_cnt))
    else $error("capture A missed counter value");
  AST_BLANK: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode == MODE_PWM && s_r.pcr1[B_BLANK_SYNC_ENABLE] && rise[3] && !hz_clr && !wr)
    |-> ##2 pwm_pin_oe == 6'h00)
    else $error("blanking did not float PWM pins");
  AST_HALT: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_r.pcr1[B_HALT] && !tb_clr) |=> (s_r.pcnt == $past(s_r.pcnt)) && pwm_pin_oe == 6'h00)
    else $error("halt did not hold PWM");
  AST_UPONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    (pstep && !s_r.pcr1[B_UPDOWN] && s_r.pcnt < s_r.per && !tb_clr)
    |=> s_r.pcnt == $past(s_r.pcnt) + 10'h001)
    else $error("up count step wrong");
  AST_WRITE_ALL_DUTIES: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr && idx == IDX_DUTY_A && wall)
    |=> s_r.dty_buf[1] == s_r.dty_buf[0] && s_r.dty_buf[2] == s_r.dty_buf[0])
    else $error("write-all did not load all duties");
  AST_IMM: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr && idx == IDX_PERIOD && imm) |=> s_r.per == $past(pwdata[PW-1:0]))
    else $error("immediate period update missed");
  AST_DEFER: assert property (@(posedge core_clk) disable iff (!nrst)
    (!imm && !pm) |=> $stable(s_r.per) && $stable(s_r.dty))
    else $error("period or duty changed outside match");

endmodule

`default_nettype wire

/* sim/dtp_pins_model.sv */
// Purpose: Pin-side partner for the dual timer and PWM block
// Assumes: Pin inputs pass the block's synchroniser and filter
// Notes: Pulses are eight clocks wide so the filter sees them

`timescale 1ns/1ps
`default_nettype none

module dtp_pins_model (
  input wire logic core_clk,
  input wire logic [5:0] pwm_pin_out,
  input wire logic [5:0] pwm_pin_oe,
  output wire logic external_count_clock,
  output wire logic capture_event_in0,
  output wire logic capture_event_in1,
  output wire logic blanking_input,
  output wire logic [5:0] pwm_pad
);
  logic [3:0] drive_r = 4'h0;

  assign {blanking_input, capture_event_in1, capture_event_in0, external_count_clock} = drive_r;
  // Released pins fall to the board pull-down
  assign pwm_pad = pwm_pin_oe & pwm_pin_out;

  // Whole pulses on one pin: 0 count, 1 and 2 capture, 3 blank
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      drive_r[which] <= 1'b1;
      repeat (8) @(posedge core_clk);
      drive_r[which] <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the dual timer and PWM block
// Assumes: Zero wait APB slave, pins through dtp_pins_model
// Notes: Register model kept in the bench, compared on reads

`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dtp_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DW-1:0] pwdata = '0;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  wire logic external_count_clock;
  wire logic capture_event_in0;
  wire logic capture_event_in1;
  wire logic blanking_input;
  logic timer_a_out_pin;
  logic timer_b_out_pin;
  logic [5:0] pwm_pin_out;
  logic [5:0] pwm_pin_oe;
  wire logic [5:0] pwm_pad;
  logic [DW-1:0] rd;
  logic err_b;
  logic p0;
  logic [5:0] e;
  logic [5:0] pol;
  logic [9:0] v;
  int model [16];
  int err_count = 0;
  int n_compared = 0;
  int n;
  int seen;
  int prev;

  always #2.5 core_clk = ~core_clk;

  dtp_top u_dtp_top (.core_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .external_count_clock, .capture_event_in0, .capture_event_in1,
    .blanking_input, .timer_a_out_pin, .timer_b_out_pin, .pwm_pin_out, .pwm_pin_oe);

  dtp_pins_model u_dtp_pins_model (.core_clk, .pwm_pin_out, .pwm_pin_oe,
    .external_count_clock, .capture_event_in0, .capture_event_in1, .blanking_input, .pwm_pad);

  // ****************************************
  // Checks, bus cycles and register model
  // ****************************************
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic [IW-1:0] idx, input logic wr, input logic [DW-1:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask

  function automatic int msk(input logic [IW-1:0] idx);
    case (idx)
      IDX_TB_CTRL: msk = int'(TB_MASK);
      IDX_PCR2: msk = int'(PCR2_MASK);
      IDX_PCR3: msk = int'(PCR3_MASK);
      IDX_PERIOD, IDX_DUTY_A, IDX_DUTY_B, IDX_DUTY_C: msk = 32'h3FF;
      default: msk = 32'hFF;
    endcase
  endfunction

  task automatic wr(input logic [IW-1:0] idx, input logic [DW-1:0] d);
    apb(idx, 1'b1, d);
    model[idx[3:0]] = int'(d & 32'(msk(idx)));
    if (idx == IDX_DUTY_A && model[3][B_WALL])
    begin
      model[14] = model[13];
      model[15] = model[13];
    end
  endtask

  task automatic rc(input logic [IW-1:0] idx);
    apb(idx, 1'b0, '0);
    chk(rd, 32'(model[idx[3:0]]), "register");
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (model[i]) model[i] = 0;
    for (int i = 2; i < 6; i++)
      rc(IW'(IDX_TA_CTRL + i));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(54023));
    do_reset();
    for (int i = 2; i < 6; i++)
    begin
      wr(IW'(IDX_TA_CTRL + i), 32'($urandom) & 32'hEE);
      rc(IW'(IDX_TA_CTRL + i));
    end
    apb(14'h1001, 1'b0, '0);
    chk({rd[30:0], err_b}, 32'h1, "unmapped");
    do_reset();
    // Capture of an external count
    wr(IDX_TA_CMP, 32'hFF);
    wr(IDX_TB_CTRL, 32'h50);
    wr(IDX_TA_CTRL, 32'hC7);
    n = 1 + $urandom % 20;
    u_dtp_pins_model.pulse(0, n);
    u_dtp_pins_model.pulse(1, 1);
    apb(IDX_TA_CAP, 1'b0, '0);
    chk(rd, 32'(n), "capture");
    // Toggle on compare match
    wr(IDX_TA_CTRL, 32'h07);
    wr(IDX_TB_CTRL, 32'h10);
    wr(IDX_TA_CMP, 32'(n + 2));
    wr(IDX_TA_CTRL, 32'h87);
    p0 = timer_a_out_pin;
    u_dtp_pins_model.pulse(0, 5);
    chk({31'h0, timer_a_out_pin}, {31'h0, ~p0}, "toggle");
    apb(IDX_TA_CNT, 1'b0, '0);
    chk(rd, 32'h2, "count after match");
    wr(IDX_TB_CMP, 32'h3);
    wr(IDX_TB_CTRL, 32'h30);
    p0 = timer_b_out_pin;
    repeat (5) @(posedge core_clk);
    chk({31'h0, timer_b_out_pin}, {31'h0, ~p0}, "timer b toggle");
    // Combined 16-bit compare
    wr(IDX_TA_CMP, 32'h4);
    wr(IDX_TB_CMP, 32'h0);
    wr(IDX_TB_CTRL, 32'h90);
    p0 = timer_a_out_pin;
    u_dtp_pins_model.pulse(0, 3);
    chk({31'h0, timer_a_out_pin}, {31'h0, ~p0}, "wide toggle");
    wr(IDX_TB_CTRL, 32'h10);
    // PWM static levels over modes, enables and polarity
    wr(IDX_PCR1, 32'h88);
    wr(IDX_PERIOD, 32'h3F);
    wr(IDX_DUTY_A, 32'h0);
    wr(IDX_DUTY_B, 32'h3FF);
    wr(IDX_DUTY_C, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      e = 6'($urandom);
      pol = 6'($urandom);
      wr(IDX_PCR1, 32'h88 | 32'(i) | 32'((i % 2) * 32));
      wr(IDX_PCR2, 32'(e));
      wr(IDX_PCR3, 32'(pol));
      repeat (4) @(posedge core_clk);
      chk(32'(pwm_pin_oe), 32'(e), "enables");
      chk(32'(pwm_pad), 32'(e & (6'h19 ^ pol)), "levels");
    end
    // Count direction
    wr(IDX_PCR3, 32'h0);
    wr(IDX_PCR2, 32'h3F);
    for (int ud = 0; ud < 2; ud++)
    begin
      wr(IDX_PCR1, 32'h88 | 32'(ud * 32));
      seen = 0;
      prev = 0;
      repeat (60)
      begin
        apb(IDX_TB_CNT, 1'b0, '0);
        if (int'(rd) < prev && prev - int'(rd) < 8)
          seen = 1;
        prev = int'(rd);
      end
      chk(32'(seen), 32'(ud), "down count");
    end
    // Halt
    wr(IDX_PCR1, 32'h98);
    repeat (4) @(posedge core_clk);
    chk(32'(pwm_pin_oe), 32'h0, "halt enables");
    apb(IDX_TB_CNT, 1'b0, '0);
    v = rd[9:0];
    repeat (20) @(posedge core_clk);
    apb(IDX_TB_CNT, 1'b0, '0);
    chk(rd, 32'(v), "held count");
    // Write-all and force-all
    wr(IDX_PCR1, 32'h8C);
    wr(IDX_DUTY_A, 32'($urandom) | 32'h3C0);
    rc(IDX_DUTY_B);
    rc(IDX_DUTY_C);
    wr(IDX_PCR1, 32'h88);
    wr(IDX_DUTY_B, 32'h0);
    wr(IDX_DUTY_C, 32'h0);
    wr(IDX_PCR2, 32'hBF);
    repeat (4) @(posedge core_clk);
    chk(32'(pwm_pad), 32'h2A, "forced");
    // Blanking
    wr(IDX_PCR2, 32'h3F);
    wr(IDX_PCR1, 32'h80);
    wr(IDX_DUTY_B, 32'h3FF);
    chk(32'(pwm_pad), 32'h25, "duty held");
    repeat (70) @(posedge core_clk);
    chk(32'(pwm_pad), 32'h29, "duty at match");
    u_dtp_pins_model.pulse(3, 1);
    chk(32'(pwm_pin_oe), 32'h3F, "blank ignored");
    wr(IDX_PCR1, 32'hC8);
    u_dtp_pins_model.pulse(3, 1);
    chk(32'(pwm_pin_oe), 32'h0, "blanked");
    wr(IDX_PCR3, 32'h80);
    repeat (4) @(posedge core_clk);
    chk(32'(pwm_pin_oe), 32'h3F, "unblanked");
    do_reset();
    tally_and_finish();
  end
endmodule

`default_nettype wire
